// ---- logic/rstc_pkg.sv ----
package rstc_pkg;
  // ****************************************
  // register indices (byte address = index*4)
  // ****************************************
  localparam logic [7:0] RSTC_IDX_FCORR_HI   = 8'h1B;
  localparam logic [7:0] RSTC_IDX_FCORR_LO   = 8'h1C;
  localparam logic [7:0] RSTC_IDX_FERR_HI    = 8'h1D;
  localparam logic [7:0] RSTC_IDX_FERR_LO    = 8'h1E;
  localparam logic [7:0] RSTC_IDX_PDET_CFG   = 8'h1F;
  localparam logic [7:0] RSTC_IDX_RSSI_TO    = 8'h20;
  localparam logic [7:0] RSTC_IDX_PRE_TO     = 8'h21;
  localparam logic [7:0] RSTC_IDX_SYNC_TO    = 8'h22;
  localparam logic [7:0] RSTC_IDX_RST_DLY    = 8'h23;
  localparam logic [7:0] RSTC_IDX_OSC        = 8'h24;
  localparam logic [7:0] RSTC_IDX_TXPRE_HI   = 8'h25;
  localparam logic [7:0] RSTC_IDX_TXPRE_LO   = 8'h26;
  localparam logic [7:0] RSTC_IDX_SYNC_CFG   = 8'h27;
  localparam logic [7:0] RSTC_IDX_IRQ_STAT   = 8'h40;
  localparam logic [7:0] RSTC_IDX_IRQ_MASK   = 8'h41;
  localparam logic [7:0] RSTC_IDX_MODE_CTRL  = 8'h42;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RSTC_RST_PDET_CFG   = 8'hAA; // on, 2 bytes, tol 0x0A
  localparam logic [2:0] RSTC_RST_CLKSEL     = 3'h7;
  localparam logic [7:0] RSTC_RST_TXPRE_LO   = 8'h03;
  localparam logic [7:0] RSTC_RST_SYNC_CFG   = 8'h93; // restart 10, sync on, size 3
  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int         RSTC_POS_PDET_EN    = 7;
  localparam int         RSTC_POS_RCCAL      = 3;
  localparam int         RSTC_POS_POLARITY   = 5;
  localparam int         RSTC_POS_SYNC_EN    = 4;
  localparam int         RSTC_POS_FILL       = 3;
  localparam logic [1:0] RSTC_PDET_RESERVED  = 2'h3;
  localparam logic [2:0] RSTC_CLK_RC         = 3'h6;
  localparam logic [2:0] RSTC_CLK_OFF        = 3'h7;
  localparam logic [1:0] RSTC_RESTART_OFF    = 2'h0;
  localparam logic [1:0] RSTC_RESTART_NOWAIT = 2'h1;
  localparam logic [1:0] RSTC_RESTART_LOCK   = 2'h2;
  localparam logic [7:0] RSTC_PATTERN_POS    = 8'hAA;
  localparam logic [7:0] RSTC_PATTERN_NEG    = 8'h55;
  localparam int         RSTC_TO_BITS        = 16;
  localparam int         RSTC_DLY_BITS       = 4;
  localparam int         RSTC_CHIPS_PER_BIT  = 4;
  // ****************************************
  // status bits
  // ****************************************
  localparam int         RSTC_ST_RSSI_TO     = 0;
  localparam int         RSTC_ST_PRE_TO      = 1;
  localparam int         RSTC_ST_SYNC_TO     = 2;
  localparam int         RSTC_ST_PRE_DET     = 3;
  localparam int         RSTC_ST_RESTART     = 4;
endpackage

// ---- logic/rstc_regs.sv ----
`timescale 1ns/1ps
// Functional notes
// - correction is 16-bit signed, write replaces it
// - error shown as signed 16-bit count
// - preamble detector enable, gain phase overrides
// - size 00/01/10 = 1/2/3 bytes, 11 reserved
// - chip errors tolerated, four chips per bit
// - signal-strength timeout, count*16 bits, 0 off
// - preamble timeout, count*16 bits, 0 off
// - sync match timeout, count*16 bits, 0 off
// - restart delayed by count*4 bit periods
// - calibration trigger self-clears, standby only
// - clock out divider, rc or off
// - tx preamble 16-bit length, resets 3
// - auto restart off, nowait, wait lock
// - preamble pattern AA or 55
// - one sync enable for tx and rx
// - fifo fill after sync or while set
// - sync length size+1, or size compat
module rstc_regs
  import rstc_pkg::*;
(
  input  wire logic        mclk_in,            // system clock
  input  wire logic        resetn_in,          // async reset, active low
  input  wire logic        psel_in,            // apb select
  input  wire logic        penable_in,         // apb access phase
  input  wire logic        pwrite_in,          // apb direction
  input  wire logic [9:0]  paddr_in,           // apb byte address
  input  wire logic [31:0] pwdata_in,          // apb write data
  input  wire logic [15:0] freq_error_in,      // measured error from modem
  input  wire logic        bit_tick_in,        // one pulse per bit period
  input  wire logic        rx_start_in,        // pulse: receive mode entered
  input  wire logic        rx_active_in,       // level: receiving
  input  wire logic        rssi_event_in,      // pulse: signal above threshold
  input  wire logic        preamble_event_in,  // pulse: preamble detected
  input  wire logic        sync_event_in,      // pulse: sync match
  input  wire logic        packet_ok_in,       // pulse: valid packet
  input  wire logic        pll_lock_in,        // synthesizer locked
  input  wire logic        agc_phase_in,       // startup / gain phase
  input  wire logic        agc_pdet_en_in,     // gain-control detector enable
  input  wire logic        standby_in,         // chip in standby
  input  wire logic        xtal_clk_in,        // crystal clock, other domain
  input  wire logic        rc_clk_in,          // rc oscillator, other domain
  output logic [31:0]      prdata_out,         // apb read data
  output logic             pready_out,         // apb ready
  output logic             pslverr_out,        // apb error
  output logic             irq_out,            // level interrupt
  output logic [15:0]      freq_correction_out,// applied correction
  output logic             preamble_detect_enable_out,
  output logic [1:0]       preamble_detect_length_out,
  output logic [4:0]       preamble_chip_error_tolerance_out,
  output logic             rc_calibration_trigger_out,
  output logic             rc_osc_enable_out,
  output logic             clock_out,          // divided clock output
  output logic [15:0]      tx_preamble_length_out,
  output logic [7:0]       preamble_pattern_out,
  output logic             sync_word_enable_out,
  output logic             fifo_store_out,     // receive data may enter fifo
  output logic [3:0]       sync_word_length_out,
  output logic             rx_restart_out      // pulse: restart receiver
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    RSTC_RS_IDLE = 2'h0,
    RSTC_RS_DLY  = 2'h1,
    RSTC_RS_LOCK = 2'h3
  } rstc_rs_type;

  typedef struct packed {
    logic [15:0] fcorr;        // correction value
    logic [7:0]  ferr_lo_hold; // latched low byte
    logic [7:0]  pdet;         // detector config
    logic [7:0]  to_rssi;      // timeout counts
    logic [7:0]  to_pre;
    logic [7:0]  to_sync;
    logic [7:0]  rdly;         // restart delay
    logic [2:0]  clksel;       // clock out select
    logic [15:0] txpre;        // tx preamble length
    logic [7:0]  scfg;         // sync config
    logic        compat;       // home automation compat
    logic [4:0]  stat;         // sticky events
    logic [4:0]  mask;         // interrupt mask
    logic        rccal;        // calibration pulse
    logic [11:0] cnt_rssi;     // bit counters (count*16)
    logic [11:0] cnt_pre;
    logic [11:0] cnt_sync;
    logic        arm_rssi;     // timers running
    logic        arm_pre;
    logic        arm_sync;
    logic        synced;       // sync seen this packet
    rstc_rs_type rs;           // restart sequencer
    logic [9:0]  rcnt;         // restart delay counter
    logic        restart;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        pdet_en;
    logic        fstore;
    logic [7:0]  pattern;      // preamble pattern
    logic [3:0]  slen;         // sync word length
    logic        rcen;         // rc oscillator enable
  } rstc_st_type;

  rstc_st_type s_q;  // registered state
  rstc_st_type s_d;  // next state

  // crystal clock sync and divider (2 flops before use)
  logic [1:0] xs_q;   // xtal synchroniser
  logic [1:0] rs_q;   // rc synchroniser
  logic       xprev_q;
  logic [4:0] div_q;  // divider over sampled crystal edges
  logic       clk_q;

  // ****************************************
  // helpers
  // ****************************************
  // timeout limit: count * 16 bit periods
  function automatic logic [11:0] to_lim(input logic [7:0] c);
    to_lim = {c, 4'h0};
  endfunction

  logic [7:0] idx;  // register index from byte address
  assign idx = paddr_in[9:2];
  logic acc;        // access phase
  assign acc = psel_in & penable_in;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    logic [4:0] ev;
    logic [7:0] rd;
    logic       hit;
    ev = 5'h0;
    rd = 8'h0;
    hit = 1'b1;
    s_d = s_q;
    s_d.rccal   = 1'b0;
    s_d.restart = 1'b0;
    s_d.pready  = psel_in & ~penable_in;  // no wait state: ready in the first access cycle
    s_d.pslverr = 1'b0;
    // read mux
    unique case (idx)
      RSTC_IDX_FCORR_HI: rd = s_q.fcorr[15:8];
      RSTC_IDX_FCORR_LO: rd = s_q.fcorr[7:0];
      RSTC_IDX_FERR_HI:  rd = freq_error_in[15:8];
      RSTC_IDX_FERR_LO:  rd = s_q.ferr_lo_hold;
      RSTC_IDX_PDET_CFG: rd = s_q.pdet;
      RSTC_IDX_RSSI_TO:  rd = s_q.to_rssi;
      RSTC_IDX_PRE_TO:   rd = s_q.to_pre;
      RSTC_IDX_SYNC_TO:  rd = s_q.to_sync;
      RSTC_IDX_RST_DLY:  rd = s_q.rdly;
      RSTC_IDX_OSC:      rd = {5'h0, s_q.clksel};
      RSTC_IDX_TXPRE_HI: rd = s_q.txpre[15:8];
      RSTC_IDX_TXPRE_LO: rd = s_q.txpre[7:0];
      RSTC_IDX_SYNC_CFG: rd = s_q.scfg;
      RSTC_IDX_IRQ_STAT: rd = {3'h0, s_q.stat};
      RSTC_IDX_IRQ_MASK: rd = {3'h0, s_q.mask};
      RSTC_IDX_MODE_CTRL: rd = {7'h0, s_q.compat};
      default: hit = 1'b0;
    endcase
    // read data and error load with ready, so both stand at the completion edge
    if (psel_in && !penable_in) begin
      s_d.pslverr = ~hit;
      if (!pwrite_in) begin
        s_d.prdata = {24'h0, rd};
        if (idx == RSTC_IDX_FERR_HI) begin
          s_d.ferr_lo_hold = freq_error_in[7:0];
        end
      end
    end
    // writes take effect at the completion edge
    if (acc && s_q.pready) begin
      if (pwrite_in) begin
        unique case (idx)
          RSTC_IDX_FCORR_HI: s_d.fcorr[15:8] = pwdata_in[7:0];
          RSTC_IDX_FCORR_LO: s_d.fcorr[7:0]  = pwdata_in[7:0];
          RSTC_IDX_PDET_CFG: s_d.pdet = pwdata_in[7:0];
          RSTC_IDX_RSSI_TO:  s_d.to_rssi = pwdata_in[7:0];
          RSTC_IDX_PRE_TO:   s_d.to_pre = pwdata_in[7:0];
          RSTC_IDX_SYNC_TO:  s_d.to_sync = pwdata_in[7:0];
          RSTC_IDX_RST_DLY:  s_d.rdly = pwdata_in[7:0];
          RSTC_IDX_OSC: begin
            s_d.clksel = pwdata_in[2:0];
            s_d.rccal  = pwdata_in[RSTC_POS_RCCAL] & standby_in;
          end
          RSTC_IDX_TXPRE_HI: s_d.txpre[15:8] = pwdata_in[7:0];
          RSTC_IDX_TXPRE_LO: s_d.txpre[7:0]  = pwdata_in[7:0];
          RSTC_IDX_SYNC_CFG: s_d.scfg = pwdata_in[7:0];
          RSTC_IDX_IRQ_MASK: s_d.mask = pwdata_in[4:0];
          RSTC_IDX_MODE_CTRL: s_d.compat = pwdata_in[0];
          default: ;
        endcase
      end
    end
    // timeout timers: start on receive entry, stop on their event
    if (rx_start_in) begin
      s_d.arm_rssi = (s_q.to_rssi != 8'h00);
      s_d.arm_pre  = (s_q.to_pre != 8'h00);
      s_d.arm_sync = (s_q.to_sync != 8'h00);
      s_d.cnt_rssi = 12'h0;
      s_d.cnt_pre  = 12'h0;
      s_d.cnt_sync = 12'h0;
      s_d.synced   = 1'b0;
    end else begin
      if (rssi_event_in) s_d.arm_rssi = 1'b0;
      if (preamble_event_in) s_d.arm_pre = 1'b0;
      if (sync_event_in) begin
        s_d.arm_sync = 1'b0;
        s_d.synced   = 1'b1;
      end
      if (bit_tick_in) begin
        if (s_q.arm_rssi && !rssi_event_in) begin
          s_d.cnt_rssi = s_q.cnt_rssi + 12'h1;
          if (s_d.cnt_rssi == to_lim(s_q.to_rssi)) begin
            ev[RSTC_ST_RSSI_TO] = 1'b1;
            s_d.arm_rssi = 1'b0;
          end
        end
        if (s_q.arm_pre && !preamble_event_in) begin
          s_d.cnt_pre = s_q.cnt_pre + 12'h1;
          if (s_d.cnt_pre == to_lim(s_q.to_pre)) begin
            ev[RSTC_ST_PRE_TO] = 1'b1;
            s_d.arm_pre = 1'b0;
          end
        end
        if (s_q.arm_sync && !sync_event_in) begin
          s_d.cnt_sync = s_q.cnt_sync + 12'h1;
          if (s_d.cnt_sync == to_lim(s_q.to_sync)) begin
            ev[RSTC_ST_SYNC_TO] = 1'b1;
            s_d.arm_sync = 1'b0;
          end
        end
      end
    end
    if (!rx_active_in) s_d.synced = 1'b0;
    ev[RSTC_ST_PRE_DET] = preamble_event_in;
    // restart sequencer after a valid packet
    unique case (s_q.rs)
      RSTC_RS_IDLE: begin
        if (packet_ok_in && s_q.scfg[7:6] != RSTC_RESTART_OFF &&
            s_q.scfg[7:6] != 2'h3) begin
          s_d.rs   = RSTC_RS_DLY;
          s_d.rcnt = 10'h0;
        end
      end
      RSTC_RS_DLY: begin
        if (s_q.rcnt == {s_q.rdly, 2'h0}) begin
          s_d.rs = (s_q.scfg[7:6] == RSTC_RESTART_LOCK) ? RSTC_RS_LOCK : RSTC_RS_IDLE;
          s_d.restart = (s_q.scfg[7:6] == RSTC_RESTART_NOWAIT);
        end else if (bit_tick_in) begin
          s_d.rcnt = s_q.rcnt + 10'h1;
        end
      end
      RSTC_RS_LOCK: begin
        if (pll_lock_in) begin
          s_d.rs      = RSTC_RS_IDLE;
          s_d.restart = 1'b1;
        end
      end
      default: s_d.rs = RSTC_RS_IDLE;
    endcase
    ev[RSTC_ST_RESTART] = s_d.restart;
    // sticky status: set wins over read-clear
    if (acc && s_q.pready && !pwrite_in && idx == RSTC_IDX_IRQ_STAT) begin
      // clear only the bits that were reported; later events survive
      s_d.stat = (s_q.stat & ~s_q.prdata[4:0]) | ev;
    end else begin
      s_d.stat = s_q.stat | ev;
    end
    s_d.irq = |(s_d.stat & s_d.mask);
    // detector enable: gain phase overrides register bit
    s_d.pdet_en = agc_phase_in ? agc_pdet_en_in : s_d.pdet[RSTC_POS_PDET_EN];
    // fifo fill condition
    s_d.fstore = rx_active_in & (s_d.scfg[RSTC_POS_FILL] |
                 (s_d.scfg[RSTC_POS_SYNC_EN] & (s_d.synced | sync_event_in)));
    // decoded config outputs, registered so every output leaves a flop
    s_d.pattern = s_d.scfg[RSTC_POS_POLARITY] ? RSTC_PATTERN_NEG : RSTC_PATTERN_POS;
    s_d.slen    = s_d.compat ? {1'b0, s_d.scfg[2:0]} : {1'b0, s_d.scfg[2:0]} + 4'h1;
    s_d.rcen    = (s_d.clksel == RSTC_CLK_RC);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q        <= '0;
      s_q.pdet   <= RSTC_RST_PDET_CFG;
      s_q.clksel <= RSTC_RST_CLKSEL;
      s_q.txpre  <= {8'h00, RSTC_RST_TXPRE_LO};
      s_q.scfg   <= RSTC_RST_SYNC_CFG;
      s_q.rs     <= RSTC_RS_IDLE;
      s_q.pdet_en <= 1'b1;
      s_q.pattern <= RSTC_PATTERN_POS;
      s_q.slen    <= {1'b0, RSTC_RST_SYNC_CFG[2:0]} + 4'h1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // clock output: sampled crystal divided, or sampled rc
  // ****************************************
  // limitation: output is rebuilt from sampled edges, so only slow sources pass cleanly
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xs_q    <= 2'h0;
      rs_q    <= 2'h0;
      xprev_q <= 1'b0;
      div_q   <= 5'h0;
      clk_q   <= 1'b0;
    end else begin
      xs_q    <= {xs_q[0], xtal_clk_in};
      rs_q    <= {rs_q[0], rc_clk_in};
      xprev_q <= xs_q[1];
      if (xs_q[1] & ~xprev_q) div_q <= div_q + 5'h1;
      unique case (s_q.clksel)
        RSTC_CLK_RC:  clk_q <= rs_q[1];
        RSTC_CLK_OFF: clk_q <= 1'b0;
        3'h0:         clk_q <= xs_q[1];
        default:      clk_q <= div_q[s_q.clksel - 3'h1];
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata_out  = s_q.prdata;
  assign pready_out  = s_q.pready;
  assign pslverr_out = s_q.pslverr;
  assign irq_out     = s_q.irq;
  assign freq_correction_out = s_q.fcorr;
  assign preamble_detect_enable_out = s_q.pdet_en;
  assign preamble_detect_length_out = s_q.pdet[6:5];
  assign preamble_chip_error_tolerance_out = s_q.pdet[4:0];
  assign rc_calibration_trigger_out = s_q.rccal;
  assign rc_osc_enable_out = s_q.rcen;
  assign clock_out = clk_q;
  assign tx_preamble_length_out = s_q.txpre;
  assign preamble_pattern_out = s_q.pattern;
  assign sync_word_enable_out = s_q.scfg[RSTC_POS_SYNC_EN];
  assign fifo_store_out = s_q.fstore;
  assign sync_word_length_out = s_q.slen;
  assign rx_restart_out = s_q.restart;

  // ****************************************
  // checks
  // ****************************************
  property p_cal_pulse;
    @(posedge mclk_in) disable iff (!resetn_in) rc_calibration_trigger_out |=> !rc_calibration_trigger_out;
  endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("cal trigger not one cycle");
  property p_pdet_override;
    @(posedge mclk_in) disable iff (!resetn_in) agc_phase_in |=> preamble_detect_enable_out == $past(agc_pdet_en_in);
  endproperty
  a_pdet_override: assert property (p_pdet_override) else $error("gain phase override lost");
  property p_sync_len;
    @(posedge mclk_in) disable iff (!resetn_in)
      !s_q.compat |-> sync_word_length_out == {1'b0, s_q.scfg[2:0]} + 4'h1;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync length wrong");
  property p_pattern;
    @(posedge mclk_in) disable iff (!resetn_in)
      !s_q.scfg[RSTC_POS_POLARITY] |-> preamble_pattern_out == 8'hAA;
  endproperty
  a_pattern: assert property (p_pattern) else $error("preamble pattern wrong");
  property p_rssi_to;
    @(posedge mclk_in) disable iff (!resetn_in) rx_start_in && s_q.to_rssi == 8'h00 |=> !s_q.arm_rssi;
  endproperty
  a_rssi_to: assert property (p_rssi_to) else $error("zero count not disabled");
  property p_irq;
    @(posedge mclk_in) disable iff (!resetn_in) (|(s_q.stat & s_q.mask)) |-> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  property p_fill;
    @(posedge mclk_in) disable iff (!resetn_in) fifo_store_out |-> $past(rx_active_in);
  endproperty
  a_fill: assert property (p_fill) else $error("fifo store outside receive");
  property p_restart_off;
    @(posedge mclk_in) disable iff (!resetn_in)
      s_q.rs == RSTC_RS_IDLE && s_q.scfg[7:6] == RSTC_RESTART_OFF |=> !rx_restart_out;
  endproperty
  a_restart_off: assert property (p_restart_off) else $error("restart while off");

endmodule // rstc_regs

// ---- test/rstc_testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import rstc_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        mclk_in = 1'b0, resetn_in = 1'b0;         // clock, reset
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [9:0]  paddr_in = 10'h000;                       // byte address
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;        // bus data
  logic        pready_out, pslverr_out, irq_out, err;
  logic [15:0] freq_error_in = 16'h0, freq_correction_out, tx_preamble_length_out;
  logic        bit_tick_in = 1'b0, rx_start_in = 1'b0, rx_active_in = 1'b1;
  logic        rssi_event_in = 1'b0, preamble_event_in = 1'b0, sync_event_in = 1'b0;
  logic        packet_ok_in = 1'b0, pll_lock_in = 1'b1, agc_phase_in = 1'b0;
  logic        agc_pdet_en_in = 1'b0, standby_in = 1'b0, xtal_clk_in = 1'b0, rc_clk_in = 1'b0;
  logic        preamble_detect_enable_out, rc_calibration_trigger_out, rc_osc_enable_out;
  logic        clock_out, sync_word_enable_out, fifo_store_out, rx_restart_out, last_clk;
  logic [1:0]  preamble_detect_length_out;
  logic [4:0]  preamble_chip_error_tolerance_out;
  logic [7:0]  preamble_pattern_out;
  logic [3:0]  sync_word_length_out;
  int          num_errors = 0, checked = 0, restarts = 0, cals = 0, edges = 0, n, e;

  always #12.5 mclk_in = ~mclk_in;   // 40 MHz

  rstc_regs u_dut (.mclk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .freq_error_in, .bit_tick_in, .rx_start_in, .rx_active_in, .rssi_event_in, .preamble_event_in,
    .sync_event_in, .packet_ok_in, .pll_lock_in, .agc_phase_in, .agc_pdet_en_in, .standby_in,
    .xtal_clk_in, .rc_clk_in, .prdata_out, .pready_out, .pslverr_out, .irq_out, .freq_correction_out,
    .preamble_detect_enable_out, .preamble_detect_length_out, .preamble_chip_error_tolerance_out,
    .rc_calibration_trigger_out, .rc_osc_enable_out, .clock_out, .tx_preamble_length_out,
    .preamble_pattern_out, .sync_word_enable_out, .fifo_store_out, .sync_word_length_out,
    .rx_restart_out);

  // slow foreign clocks, and counters of one-cycle pulses so none is missed
  always @(posedge mclk_in) begin
    xtal_clk_in <= ~xtal_clk_in;
    if (xtal_clk_in) begin
      rc_clk_in <= ~rc_clk_in;
    end
    if (rx_restart_out === 1'b1) begin
      restarts++;
    end
    if (rc_calibration_trigger_out === 1'b1) begin
      cals++;
    end
    if (clock_out !== last_clk) begin
      edges++;
    end
    last_clk = clock_out;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= {idx, 2'b00};
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    if (k >= 20) begin
      num_errors++;
      end_of_test();
    end
    rd  = prdata_out;   // taken at the completion edge, where it stands
    err = pslverr_out;
    @(posedge mclk_in);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge mclk_in);
  endtask

  task automatic ticks(input int c);
    repeat (c) begin
      bit_tick_in <= 1'b1;
      @(posedge mclk_in);
      bit_tick_in <= 1'b0;
      @(posedge mclk_in);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rdc(RSTC_IDX_FCORR_HI, 32'h00);
    rdc(RSTC_IDX_PDET_CFG, 32'hAA);
    rdc(RSTC_IDX_OSC, 32'h07);
    rdc(RSTC_IDX_TXPRE_LO, 32'h03);
    rdc(RSTC_IDX_SYNC_CFG, 32'h93);
    chk(tx_preamble_length_out, 32'h3);
    chk(preamble_chip_error_tolerance_out, 32'h0A);
    chk(preamble_pattern_out, 32'hAA);
    chk(sync_word_enable_out, 32'h1);
    chk(sync_word_length_out, 32'h4);
  endtask

  task automatic t_freq();
    wr(RSTC_IDX_FCORR_HI, 32'hFE);
    wr(RSTC_IDX_FCORR_LO, 32'h12);
    chk(freq_correction_out, 32'hFE12);
    freq_error_in <= 16'hC3A5;
    idle(4);
    rdc(RSTC_IDX_FERR_HI, 32'hC3);
    freq_error_in <= 16'h5A00;           // new estimate must not leak into the low half
    idle(4);
    rdc(RSTC_IDX_FERR_LO, 32'hA5);
  endtask

  task automatic t_pdet();
    wr(RSTC_IDX_PDET_CFG, 32'h45);
    chk(preamble_detect_enable_out, 32'h0);
    chk(preamble_detect_length_out, 32'h2);
    chk(preamble_chip_error_tolerance_out, 32'h05);
    wr(RSTC_IDX_PDET_CFG, 32'h80);
    agc_phase_in <= 1'b1;   // gain phase overrides the enable bit
    idle(3);
    chk(preamble_detect_enable_out, 32'h0);
    agc_phase_in <= 1'b0;
    idle(3);
    chk(preamble_detect_enable_out, 32'h1);
  endtask

  task automatic t_timeouts();
    apb(1'b0, RSTC_IDX_IRQ_STAT, 32'h0);   // drop stale events
    wr(RSTC_IDX_IRQ_MASK, 32'h01);
    wr(RSTC_IDX_RSSI_TO, 32'h01);
    wr(RSTC_IDX_PRE_TO, 32'h02);
    wr(RSTC_IDX_SYNC_TO, 32'h03);
    rx_start_in <= 1'b1;
    idle(1);
    rx_start_in <= 1'b0;
    ticks(15);
    idle(2);
    chk(irq_out, 32'h0);
    ticks(1);
    idle(2);
    chk(irq_out, 32'h1);
    rdc(RSTC_IDX_IRQ_STAT, 32'h01);
    chk(irq_out, 32'h0);
    ticks(16);
    idle(2);
    chk(irq_out, 32'h0);
    rdc(RSTC_IDX_IRQ_STAT, 32'h02);
    ticks(16);
    rdc(RSTC_IDX_IRQ_STAT, 32'h04);
    wr(RSTC_IDX_IRQ_MASK, 32'h00);
  endtask

  task automatic t_restart();
    wr(RSTC_IDX_RST_DLY, 32'h01);
    for (int m = 0; m < 3; m++) begin
      wr(RSTC_IDX_SYNC_CFG, (m == 0) ? 32'h53 : ((m == 1) ? 32'h93 : 32'h13));
      pll_lock_in <= (m != 1);
      n = restarts;
      packet_ok_in <= 1'b1;
      idle(1);
      packet_ok_in <= 1'b0;
      ticks(3);
      idle(2);
      chk(restarts, n);
      ticks(2);
      idle(3);
      chk(restarts, n + (m == 0));
      pll_lock_in <= 1'b1;                 // relock releases the waiting mode
      idle(4);
      chk(restarts, n + (m < 2));
    end
  endtask

  task automatic t_sync();
    wr(RSTC_IDX_SYNC_CFG, 32'hA3);
    chk(preamble_pattern_out, 32'h55);
    chk(sync_word_enable_out, 32'h0);
    wr(RSTC_IDX_MODE_CTRL, 32'h01);
    chk(sync_word_length_out, 32'h3);
    wr(RSTC_IDX_SYNC_CFG, 32'h9B);
    chk(fifo_store_out, 32'h1);
    wr(RSTC_IDX_SYNC_CFG, 32'h93);
    wr(RSTC_IDX_TXPRE_HI, 32'h12);
    chk(tx_preamble_length_out, 32'h1203);
    wr(RSTC_IDX_RSSI_TO, 32'h00);
    rx_start_in <= 1'b1;
    idle(1);
    rx_start_in <= 1'b0;
    idle(2);
    chk(fifo_store_out, 32'h0);
    sync_event_in <= 1'b1;
    idle(1);
    sync_event_in <= 1'b0;
    idle(2);
    chk(fifo_store_out, 32'h1);
  endtask

  task automatic t_osc();
    n = cals;
    wr(RSTC_IDX_OSC, 32'h0F);              // outside standby: no calibration
    idle(2);
    chk(cals, n);
    standby_in <= 1'b1;
    wr(RSTC_IDX_OSC, 32'h0F);
    idle(2);
    chk(cals, n + 1);
    rdc(RSTC_IDX_OSC, 32'h07);
    wr(RSTC_IDX_OSC, 32'h00);
    idle(6);
    e = edges;
    idle(40);
    chk({31'h0, (edges - e) > 8}, 32'h1);
    wr(RSTC_IDX_OSC, 32'h07);
    idle(6);
    e = edges;
    idle(20);
    chk(edges - e, 0);
    wr(RSTC_IDX_OSC, 32'h06);
    chk(rc_osc_enable_out, 32'h1);
    apb(1'b0, 8'h30, 32'h0);               // unmapped place
    chk(err, 32'h1);
  endtask

  initial begin
    repeat (10) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_freq();
    t_pdet();
    t_timeouts();
    t_restart();
    t_sync();
    t_osc();
    end_of_test();
  end
endmodule // testbench
